/* File: tpb_pkg.sv */
// constants for the timer, pwm and buzzer block
// Functional notes
// RULE_01 - reading count register returns live 8-bit down-counter value
// RULE_02 - writing count register loads reload register and live counter together
// RULE_03 - counter counts only while run-enable is 1
// RULE_04 - continuous mode, reload-select 1: underflow reloads reload value
// RULE_05 - continuous mode, reload-select 0: underflow loads 0xFF
// RULE_06 - one-shot: count once down to 0x00 then stop
// RULE_07 - pwm polarity 1 gives active low, 0 active high
// RULE_08 - pwm output enable routes pwm onto shared pin, else pin is gpio
// RULE_09 - pwm inactive after start, active from count equals duty until underflow
// RULE_10 - period from reload value, duty from write-only duty register
// RULE_11 - 3-bit prescaler rate selects 1:2 up to 1:256 in doubling steps
// RULE_12 - prescaler bypass bit 1 bypasses prescaler, 0 inserts it
// RULE_13 - software changes prescaler rate only while prescaler bypassed
// RULE_14 - external edge select 1 counts falling edges, 0 rising edges
// RULE_15 - clock source 0 uses instruction clock, 1 uses external pin
// RULE_16 - reading prescaler view returns the 8-bit prescaler counter
// RULE_17 - buzzer codes 0-7 pick prescaler taps, 8-15 pick timer bits 0-7
// RULE_18 - buzzer enable 1 drives buzzer wave onto shared pin
// RULE_19 - shared pin is external clock input when external clock selected
// RULE_20 - one-cycle underflow event each time count passes 0x00
// RULE_21 - pwm holds inactive level while timer disabled
package tpb_pkg;
    localparam int ADDR_W = 5;
    // byte address is four times the register index
    localparam logic [2:0] IDX_COUNT = 3'h0;
    localparam logic [2:0] IDX_CTRL_A = 3'h1;
    localparam logic [2:0] IDX_CTRL_B = 3'h2;
    localparam logic [2:0] IDX_DUTY = 3'h3;
    localparam logic [2:0] IDX_PS_VIEW = 3'h4;
    localparam logic [2:0] IDX_BUZZ = 3'h5;
    localparam logic [2:0] IDX_LAST = 3'h5;
    // control a fields
    localparam int CA_RUN = 0;
    localparam int CA_RELOAD = 1;
    localparam int CA_ONESHOT = 2;
    localparam int CA_POL = 6;
    localparam int CA_PWM_OE = 7;
    // control b fields
    localparam int CB_RATE_LO = 0;
    localparam int CB_BYPASS_N = 3;
    localparam int CB_EDGE = 4;
    localparam int CB_CLKSRC = 5;
    // buzzer fields
    localparam int BZ_TIMER_SEL = 3;
    localparam int BZ_EN = 7;
    // reset values, count limits and bus responses
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h3F;
    localparam logic [7:0] BUZZ_RST = 8'h0F;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] PS_RST = 8'h00;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_FULL = 8'hFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tpb_pkg

/* File: tpb_top.sv */
// timer with reload, prescaler, pwm and buzzer behind an axi4-lite slave
//
// Our own choice: register access over AXI4-Lite.
module tpb_top (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [tpb_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tpb_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pin_in,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    output logic pin_out,
    output logic pin_oe,
    output logic pwm_output,
    output logic buzzer_output,
    output logic underflow_pulse
);
    // register index from a byte address, legal only when in range
    function automatic logic [2:0] reg_idx(input logic [tpb_pkg::ADDR_W-1:0] a);
        reg_idx = a[tpb_pkg::ADDR_W-1:2];
    endfunction : reg_idx
    function automatic logic idx_ok(input logic [tpb_pkg::ADDR_W-1:0] a);
        idx_ok = (a[tpb_pkg::ADDR_W-1:2] <= tpb_pkg::IDX_LAST);
    endfunction : idx_ok

    logic [7:0] count_ff, reload_ff, ctrl_a_ff, ctrl_b_ff, duty_ff, ps_ff, buzz_ff;
    logic [7:0] nxt_count, nxt_ps;
    logic done_ff, pwm_act_ff, ext_prev_ff;
    logic nxt_pwm_act;
    logic aw_hold_ff, w_hold_ff;
    logic [tpb_pkg::ADDR_W-1:0] awaddr_ff;
    logic [7:0] wbyte_ff;

    // write channel: address and data taken independently, response after both
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
    wire [2:0] widx = reg_idx(awaddr_ff);
    wire wr_ok = do_write && idx_ok(awaddr_ff);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= '0;
            wbyte_ff <= 8'h00;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tpb_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_ff && !aw_take;
            s_axi_wready <= !w_hold_ff && !w_take;
            if (aw_take) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                w_hold_ff <= 1'b1;
                // only the low lane carries data; taken whatever the strobe, which gates the register write
                wbyte_ff <= s_axi_wdata[7:0];
            end
            if (do_write) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= idx_ok(awaddr_ff) ? tpb_pkg::RESP_OKAY : tpb_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // lane 0 strobe is latched with data so a masked write stores nothing
    logic wstrb0_ff;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wstrb0_ff <= 1'b0;
        end else if (w_take) begin
            wstrb0_ff <= s_axi_wstrb[0];
        end
    end
    wire wr_en = wr_ok && wstrb0_ff;
    // a masked count write must not restart a stopped one-shot either
    wire wr_count = wr_en && widx == tpb_pkg::IDX_COUNT;

    // control registers
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl_a_ff <= tpb_pkg::CTRL_A_RST;
            ctrl_b_ff <= tpb_pkg::CTRL_B_RST;
            buzz_ff <= tpb_pkg::BUZZ_RST;
            duty_ff <= tpb_pkg::COUNT_RST;
            reload_ff <= tpb_pkg::COUNT_RST;
        end else if (wr_en) begin
            case (widx)
                tpb_pkg::IDX_COUNT: reload_ff <= wbyte_ff; // see RULE_02
                tpb_pkg::IDX_CTRL_A: ctrl_a_ff <= wbyte_ff;
                tpb_pkg::IDX_CTRL_B: ctrl_b_ff <= wbyte_ff; // see RULE_13
                tpb_pkg::IDX_DUTY: duty_ff <= wbyte_ff; // see RULE_10
                tpb_pkg::IDX_BUZZ: buzz_ff <= wbyte_ff;
                default: ;
            endcase
        end
    end

    wire run_en = ctrl_a_ff[tpb_pkg::CA_RUN];
    wire reload_sel = ctrl_a_ff[tpb_pkg::CA_RELOAD];
    wire one_shot = ctrl_a_ff[tpb_pkg::CA_ONESHOT];
    wire pwm_pol = ctrl_a_ff[tpb_pkg::CA_POL];
    wire pwm_oe = ctrl_a_ff[tpb_pkg::CA_PWM_OE];
    wire [2:0] ps_rate = ctrl_b_ff[tpb_pkg::CB_RATE_LO +: 3];
    wire ps_bypass_n = ctrl_b_ff[tpb_pkg::CB_BYPASS_N];
    wire edge_fall = ctrl_b_ff[tpb_pkg::CB_EDGE];
    wire clk_src_ext = ctrl_b_ff[tpb_pkg::CB_CLKSRC];
    wire buzz_en = buzz_ff[tpb_pkg::BZ_EN];
    wire [3:0] buzz_sel = buzz_ff[3:0];

    // external pin edge detect; pin already synchronous to clk_sys
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ext_prev_ff <= 1'b0;
        end else begin
            ext_prev_ff <= pin_in;
        end
    end
    wire ext_edge = edge_fall ? (ext_prev_ff && !pin_in) : (!ext_prev_ff && pin_in); // see RULE_14
    // instruction clock is clk_sys itself: one tick each cycle
    wire src_tick = clk_src_ext ? ext_edge : 1'b1; // see RULE_15 RULE_19

    // prescaler counts source ticks; its carry out of the rate bit is the tick
    wire [7:0] ps_inc = ps_ff + 8'h01;
    wire ps_tick = src_tick && (ps_ff[ps_rate] && !ps_inc[ps_rate]); // see RULE_11
    wire timer_tick = ps_bypass_n ? src_tick : ps_tick; // see RULE_12
    assign nxt_ps = src_tick ? ps_inc : ps_ff;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ps_ff <= tpb_pkg::PS_RST;
        end else begin
            ps_ff <= nxt_ps; // see RULE_16
        end
    end

    // down-counter with reload, wrap and one-shot stop
    wire counting = run_en && !done_ff; // see RULE_03
    wire dec = counting && timer_tick;
    wire at_zero = count_ff == tpb_pkg::CNT_ZERO;
    wire uflow = dec && at_zero; // see RULE_20
    wire [7:0] refill = reload_sel ? reload_ff : tpb_pkg::CNT_FULL; // see RULE_04 RULE_05
    always_comb begin
        nxt_count = count_ff;
        if (wr_en && widx == tpb_pkg::IDX_COUNT) begin
            nxt_count = wbyte_ff; // see RULE_02
        end else if (uflow) begin
            nxt_count = one_shot ? count_ff : refill; // see RULE_06
        end else if (dec) begin
            nxt_count = count_ff - 8'h01;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            count_ff <= tpb_pkg::COUNT_RST;
            done_ff <= 1'b0;
            underflow_pulse <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            underflow_pulse <= uflow; // see RULE_20
            // one-shot stop lifts on a new count write or disable
            if (wr_count || !run_en) begin
                done_ff <= 1'b0;
            end else if (uflow && one_shot) begin
                done_ff <= 1'b1; // see RULE_06
            end
        end
    end

    // pwm active from duty match until underflow, inactive while disabled
    // decided on the count about to be shown, so output and count stay in step
    always_comb begin
        nxt_pwm_act = pwm_act_ff;
        if (!run_en) begin
            nxt_pwm_act = 1'b0; // see RULE_21
        end else if (uflow && !wr_count) begin
            // a frame whose reload equals duty starts active
            nxt_pwm_act = !one_shot && refill == duty_ff; // see RULE_09
        end else if ((dec || wr_count) && nxt_count == duty_ff) begin
            nxt_pwm_act = 1'b1; // see RULE_09
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pwm_act_ff <= 1'b0;
        end else begin
            pwm_act_ff <= nxt_pwm_act;
        end
    end
    wire pwm_lvl = nxt_pwm_act ^ pwm_pol; // see RULE_07

    // buzzer source: prescaler tap or timer bit
    wire buzz_lvl = buzz_sel[tpb_pkg::BZ_TIMER_SEL] ? nxt_count[buzz_sel[2:0]]
                                                   : nxt_ps[buzz_sel[2:0]]; // see RULE_17

    // shared pin: pwm first, then buzzer, else gpio; external clock makes it an input
    wire pin_ext_in = clk_src_ext; // see RULE_19
    wire nxt_pin_oe = pin_ext_in ? 1'b0 : (pwm_oe || buzz_en || gpio_oe);
    wire nxt_pin_out = pwm_oe ? pwm_lvl : (buzz_en ? buzz_lvl : gpio_out); // see RULE_08 RULE_18
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            pwm_output <= 1'b0;
            buzzer_output <= 1'b0;
        end else begin
            pin_out <= nxt_pin_out;
            pin_oe <= nxt_pin_oe;
            pwm_output <= pwm_lvl;
            buzzer_output <= buzz_en && buzz_lvl; // see RULE_18
        end
    end

    // read channel: one read at a time, answered the cycle after address taken
    logic [7:0] rbyte;
    wire [2:0] ridx = reg_idx(s_axi_araddr);
    always_comb begin
        case (ridx)
            tpb_pkg::IDX_COUNT: rbyte = count_ff; // see RULE_01
            tpb_pkg::IDX_CTRL_A: rbyte = ctrl_a_ff;
            tpb_pkg::IDX_CTRL_B: rbyte = ctrl_b_ff;
            tpb_pkg::IDX_PS_VIEW: rbyte = ps_ff; // see RULE_16
            default: rbyte = 8'h00; // duty and buzzer are write-only
        endcase
    end
    wire ar_take = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= tpb_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_take && !s_axi_arready;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, idx_ok(s_axi_araddr) ? rbyte : 8'h00};
                s_axi_rresp <= idx_ok(s_axi_araddr) ? tpb_pkg::RESP_OKAY : tpb_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // checks: registered results held against their cause one cycle earlier
    a_underflow_pulse: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_20
        uflow |=> underflow_pulse) else $error("underflow pulse missing");
    a_pulse_single: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_20
        underflow_pulse |-> $past(count_ff) == tpb_pkg::CNT_ZERO)
        else $error("pulse without underflow");
    a_wrap_full: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_05
        uflow && !one_shot && !reload_sel && !wr_count |=> count_ff == tpb_pkg::CNT_FULL)
        else $error("no wrap to full");
    a_reload_val: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_04
        uflow && !one_shot && reload_sel && !wr_count |=> count_ff == $past(reload_ff))
        else $error("no reload");
    a_oneshot_stop: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_06
        uflow && one_shot && !wr_count && run_en |=> done_ff && count_ff == tpb_pkg::CNT_ZERO)
        else $error("one-shot kept counting");
    a_hold_disabled: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_03
        !run_en && !wr_count |=> count_ff == $past(count_ff))
        else $error("counter moved while disabled");
    a_write_loads: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_02
        wr_count |=> count_ff == reload_ff)
        else $error("count write not loaded");
    // polarity may change in a write made while the timer is stopped
    a_pwm_idle_off: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_21
        !run_en |=> pwm_output == $past(pwm_pol)) else $error("pwm active while off");
    a_pwm_uflow_off: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_09
        uflow && !one_shot && refill != duty_ff && !wr_count |=> pwm_output == $past(pwm_pol))
        else $error("pwm still active after underflow");
    a_pin_input: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_19
        clk_src_ext |=> !pin_oe) else $error("pin driven in ext clock");
    a_buzz_off: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_18
        !buzz_en |=> !buzzer_output) else $error("buzzer toggles while disabled");
    c_wrap: cover property (@(posedge clk_sys) disable iff (!nrst) uflow && !one_shot);
    c_oneshot: cover property (@(posedge clk_sys) disable iff (!nrst) uflow && one_shot);
    c_pwm_on: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(pwm_act_ff));
    c_ps_tick: cover property (@(posedge clk_sys) disable iff (!nrst) ps_tick && !ps_bypass_n);
    c_ext_tick: cover property (@(posedge clk_sys) disable iff (!nrst) clk_src_ext && dec);
endmodule : tpb_top

/* File: tpb_pin_model.sv */
// shared pin load: pull-up plus an external clock source for the timer
module tpb_pin_model (
    input wire logic clk_sys,
    input wire logic ext_run,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_in,
    output int rise_cnt,
    output int fall_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lvl = 1'b1;
    int ph = 0;
    int rc = 0;
    int fc = 0;
    // edge every 3 cycles; a low phase always finishes high so the clock stands still high
    always @(posedge clk_sys) begin
        ph <= (ph == 2) ? 0 : ph + 1;
        if ((ext_run || !lvl) && ph == 2) begin
            lvl <= !lvl;
            if (lvl) fc <= fc + 1;
            else rc <= rc + 1;
        end
    end
    // released pin follows the clock source, which rests at the pull-up level
    assign pin_in = pin_oe ? pin_out : lvl;
    assign rise_cnt = rc;
    assign fall_cnt = fc;
endmodule : tpb_pin_model

/* File: tb.sv */
// self-checking bench for the timer, pwm and buzzer block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] CNT = tpb_pkg::IDX_COUNT;
    localparam logic [2:0] CA = tpb_pkg::IDX_CTRL_A;
    localparam logic [2:0] CB = tpb_pkg::IDX_CTRL_B;
    localparam logic [2:0] BZ = tpb_pkg::IDX_BUZZ;
    localparam logic [1:0] OK = tpb_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = tpb_pkg::RESP_SLVERR;
    logic clk_sys, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pin_in, gpio_out, gpio_oe, pin_out, pin_oe;
    logic pwm, buzz, ufl, ext_run, meas_stb, prev;
    logic [tpb_pkg::ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, meas_val, seed;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [33:0] exp_q[$];
    int fail_count, cmp_count, rise_cnt, fall_cnt, c, g, r0, f0;

    tpb_top i_tpb_top (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_in(pin_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .pin_out(pin_out), .pin_oe(pin_oe), .pwm_output(pwm), .buzzer_output(buzz),
        .underflow_pulse(ufl));
    tpb_pin_model i_tpb_pin_model (.clk_sys(clk_sys), .ext_run(ext_run), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in), .rise_cnt(rise_cnt), .fall_cnt(fall_cnt));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction : xs

    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        cmp_count++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task automatic tmo();
        fail_count++;
        complete_run();
    endtask : tmo

    // one result appears per bus answer or measurement; oldest note is its expectation
    always @(posedge clk_sys) begin
        if (rvalid && rready) check({rresp, rdata}, exp_q.pop_front());
        else if (bvalid && bready) check({bresp, 32'h0}, exp_q.pop_front());
        else if (meas_stb) check({2'h0, meas_val}, exp_q.pop_front());
    end

    // axi write: address and data offered together, each released when taken
    task automatic wr(input logic [2:0] idx, input logic [7:0] d, input logic [1:0] resp);
        int n;
        @(posedge clk_sys);
        exp_q.push_back({resp, 32'h0});
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 100) tmo();
    endtask : wr

    task automatic rd(input logic [2:0] idx, input logic [7:0] d, input logic [1:0] resp);
        int n;
        @(posedge clk_sys);
        exp_q.push_back({resp, 24'h0, d});
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 100) tmo();
    endtask : rd

    task automatic post(input logic [31:0] v, input logic [31:0] want);
        @(posedge clk_sys);
        exp_q.push_back({2'h0, want});
        meas_val <= v;
        meas_stb <= 1'b1;
        @(posedge clk_sys);
        meas_stb <= 1'b0;
    endtask : post

    // timer stopped while reconfiguring, started last
    task automatic setup(input logic [7:0] ca, cb, cnt, duty);
        wr(CA, 8'h00, OK);
        wr(CB, cb, OK);
        wr(tpb_pkg::IDX_DUTY, duty, OK);
        wr(CNT, cnt, OK);
        wr(CA, ca, OK);
    endtask : setup

    // cycles between two underflow pulses, bounded
    task automatic period(input int want);
        repeat (2) begin
            for (c = 0; c < 2000 && !ufl; c++) @(posedge clk_sys);
            @(posedge clk_sys);
            for (g = 1; g < 2000 && !ufl; g++) @(posedge clk_sys);
            if (g == 2000) tmo();
        end
        post(g, want);
    endtask : period

    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready, gpio_out, gpio_oe} = '0;
        {ext_run, meas_stb, awaddr, araddr, wdata, meas_val} = '0;
        wstrb = 4'hF;
        seed = 32'h5072;
        fail_count = 0;
        cmp_count = 0;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(CB, 8'h3F, OK);
        rd(CNT, 8'h00, OK);
        rd(tpb_pkg::IDX_PS_VIEW, 8'h00, OK);
        rd(tpb_pkg::IDX_DUTY, 8'h00, OK);
        rd(3'h6, 8'h00, ERR);
        wr(3'h7, 8'h55, ERR);
        // masked low lane stores nothing
        wstrb <= 4'hE;
        wr(CNT, 8'hAA, OK);
        wstrb <= 4'hF;
        rd(CNT, 8'h00, OK);
        $display("test reset done");
        wr(CB, 8'h08, OK);
        repeat (4) begin
            seed = xs(seed);
            wr(CNT, seed[7:0], OK);
            gpio_out <= seed[8];
            gpio_oe <= 1'b1;
            repeat (20) @(posedge clk_sys);
            rd(CNT, seed[7:0], OK);
            post({30'h0, pin_oe, pin_out}, {30'h0, 1'b1, seed[8]});
        end
        $display("test load done");
        setup(8'h07, 8'h08, 8'h05, 8'h00);
        repeat (20) @(posedge clk_sys);
        rd(CNT, 8'h00, OK);
        setup(8'h03, 8'h08, 8'h03, 8'h00);
        period(4);
        setup(8'h01, 8'h08, 8'h03, 8'h00);
        period(256);
        $display("test modes done");
        for (int r = 0; r < 8; r++) begin
            wr(CB, 8'(8'h08 | r), OK);
            setup(8'h03, 8'(r), 8'h01, 8'h00);
            period(4 << r);
        end
        $display("test prescaler done");
        for (int p = 0; p < 2; p++) begin
            setup(8'(8'h80 | (p << 6)), 8'h08, 8'h09, 8'h04);
            repeat (3) @(posedge clk_sys);
            post({30'h0, pin_oe, pwm}, 32'(2 + p));
            wr(CA, 8'(8'h83 | (p << 6)), OK);
            repeat (5) @(posedge clk_sys);
            c = 0;
            g = 0;
            repeat (40) begin
                @(posedge clk_sys);
                if (pwm !== 1'(p)) c++;
                if (pin_out !== pwm) g++;
            end
            post(c, 20);
            post(g, 0);
        end
        $display("test pwm done");
        setup(8'h01, 8'h08, 8'h00, 8'h00);
        // gpio released so only the buzzer can drive the pin
        gpio_oe <= 1'b0;
        g = 0;
        // first six codes are prescaler taps, the next six timer bits
        for (int k = 0; k < 12; k++) begin
            wr(BZ, 8'(8'h80 | (k < 6 ? 0 : 8) | (k % 6)), OK);
            repeat (4) @(posedge clk_sys);
            prev = buzz;
            c = 0;
            repeat (64) begin
                @(posedge clk_sys);
                if (buzz !== prev) c++;
                if (pin_out !== buzz) g++;
                prev = buzz;
            end
            post(c, 64 >> (k % 6));
        end
        post({31'h0, pin_oe}, 32'h1);
        post(g, 0);
        wr(BZ, 8'h08, OK);
        repeat (4) @(posedge clk_sys);
        post({31'h0, pin_oe}, 32'h0);
        c = 0;
        repeat (16) begin
            @(posedge clk_sys);
            if (buzz !== 1'b0) c++;
        end
        post(c, 0);
        $display("test buzzer done");
        for (int e = 0; e < 2; e++) begin
            setup(8'h01, 8'(8'h28 | (e << 4)), 8'h80, 8'h00);
            post({31'h0, pin_oe}, 32'h0);
            r0 = rise_cnt;
            f0 = fall_cnt;
            ext_run <= 1'b1;
            repeat (60) @(posedge clk_sys);
            ext_run <= 1'b0;
            repeat (20) @(posedge clk_sys);
            rd(CNT, 8'(8'h80 - (e ? fall_cnt - f0 : rise_cnt - r0)), OK);
        end
        $display("test external clock done");
        complete_run();
    end
endmodule : tb
